// >>> synth_lock_loss_and_disable.sv
`timescale 1ns/1ps
`include "synth_cfg.svh"
module synth_lock_loss_and_disable (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_tune_en,
    input wire logic i_vco_pre,
    input synth_pkg::reg_req_s i_reg,
    output logic [15:0] o_reg_rdata,
    output logic o_synth_en,
    output logic o_vco_pulldown,
    output logic o_ref_tick,
    output logic o_div_tick,
    output logic o_up_req_n,
    output logic o_down_req_n,
    output logic o_err_out,
    output logic o_err_oe_n,
    output logic o_lock_loss_flag
);
    import synth_pkg::*;

    // ==================================================
    // registers and decode
    logic [3:0] ref_sel_r;
    logic [1:0] dly_r;
    logic [15:0] div_val_r;
    wire wr_ref = i_reg.wr && (i_reg.addr == `ADDR_REF_SEL);
    wire wr_dly = i_reg.wr && (i_reg.addr == `ADDR_DLY_SEL);
    wire wr_div = i_reg.wr && (i_reg.addr == `ADDR_DIV_VAL);
    wire ll_clear = i_reg.rd && (i_reg.addr == `ADDR_LL_STATUS);
    wire synth_off = !i_tune_en || (ref_sel_r == `REF_CODE_OFF);
    wire dly_off = (dly_r == `DLY_CODE_OFF);

    // only power-on reset touches these; tuning enable never does
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ref_sel_r <= `REF_SEL_RST;
            dly_r <= `DLY_SEL_RST;
            div_val_r <= `DIV_VAL_RST;
        end else begin
            if (wr_ref) begin
                ref_sel_r <= i_reg.wdata[3:0];
            end
            if (wr_dly) begin
                dly_r <= i_reg.wdata[`DLY_CODE_W-1:0];
            end
            if (wr_div) begin
                div_val_r <= i_reg.wdata;
            end
        end
    end

    // ==================================================
    // reference generator
    logic [11:0] ref_cnt_r;
    logic ref_tick_r;
    // codes marked not-to-be-set simply leave the reference stopped
    wire [11:0] ref_len = (ref_sel_r == `REF_CODE_6K25) ? 12'(`REF_CYC_6K25) :
                          (ref_sel_r == `REF_CODE_12K5) ? 12'(`REF_CYC_12K5) :
                          (ref_sel_r == `REF_CODE_25K) ? 12'(`REF_CYC_25K) : 12'h000;
    wire ref_run = !synth_off && (ref_len != 12'h000);
    wire ref_end = ref_run && (ref_cnt_r == ref_len - 12'h001);

    always_ff @(posedge i_mclk) begin
        if (i_rst || !ref_run || ref_end) begin
            ref_cnt_r <= 12'h000;
        end else begin
            ref_cnt_r <= ref_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge i_mclk) begin
        ref_tick_r <= !i_rst && ref_end;
    end

    // ==================================================
    // programmable divider
    logic vco_q_r;
    logic [15:0] div_cnt_r;
    logic div_tick_r;
    wire vco_rise = i_vco_pre && !vco_q_r;
    // N of zero behaves as one rather than wrapping
    wire div_last = ({1'b0, div_cnt_r} + 17'h1) >= {1'b0, div_val_r};

    always_ff @(posedge i_mclk) begin
        if (i_rst || synth_off) begin
            div_cnt_r <= 16'h0000;
        end else if (vco_rise) begin
            div_cnt_r <= div_last ? 16'h0000 : div_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        vco_q_r <= !i_rst && i_vco_pre;
        div_tick_r <= !i_rst && !synth_off && vco_rise && div_last;
    end

    // ==================================================
    // phase comparator and charge pump
    pfd_e pfd_r;
    pfd_e pfd_nxt;

    always_comb begin
        pfd_nxt = pfd_r;
        unique case (pfd_r)
            PFD_IDLE: begin
                if (ref_tick_r && !div_tick_r) begin
                    pfd_nxt = PFD_UP;
                end else if (div_tick_r && !ref_tick_r) begin
                    pfd_nxt = PFD_DOWN;
                end
            end
            PFD_UP: begin
                if (div_tick_r) begin
                    pfd_nxt = PFD_IDLE;
                end
            end
            PFD_DOWN: begin
                if (ref_tick_r) begin
                    pfd_nxt = PFD_IDLE;
                end
            end
        endcase
        if (synth_off) begin
            pfd_nxt = PFD_IDLE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pfd_r <= PFD_IDLE;
        end else begin
            pfd_r <= pfd_nxt;
        end
    end

    // ==================================================
    // lock-loss filter and sticky flag
    logic [6:0] req_cnt_r;
    logic pend_r;
    logic flag_r;
    wire req_on = (pfd_r != PFD_IDLE);
    wire [6:0] dly_thresh = (dly_r == `DLY_CODE_MID) ? 7'(`DLY_MID_CYC) :
                            (dly_r == `DLY_CODE_LONG) ? 7'(`DLY_LONG_CYC) : 7'(`DLY_SHORT_CYC);
    wire long_req = req_on && (req_cnt_r >= dly_thresh - 7'h01);
    wire flag_set = ref_tick_r && pend_r;

    always_ff @(posedge i_mclk) begin
        if (i_rst || !req_on) begin
            req_cnt_r <= 7'h00;
        end else if (req_cnt_r != 7'h7F) begin
            req_cnt_r <= req_cnt_r + 7'h01;
        end
    end

    // a long request seen in the tick cycle survives into the next period
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pend_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            pend_r <= long_req || (pend_r && !ref_tick_r);
            flag_r <= flag_set || dly_off || (flag_r && !ll_clear);
        end
    end

    // ==================================================
    // read data and pins
    wire [15:0] rd_mux = (i_reg.addr == `ADDR_REF_SEL) ? {12'h000, ref_sel_r} :
                         (i_reg.addr == `ADDR_DLY_SEL) ? {14'h0, dly_r} :
                         (i_reg.addr == `ADDR_DIV_VAL) ? div_val_r :
                         (i_reg.addr == `ADDR_LL_STATUS) ? {15'h0, flag_r} : 16'h0000;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0000;
            o_synth_en <= 1'b0;
            o_vco_pulldown <= 1'b1;
            o_up_req_n <= 1'b1;
            o_down_req_n <= 1'b1;
            o_err_out <= 1'b0;
            o_err_oe_n <= 1'b1;
        end else begin
            o_reg_rdata <= i_reg.rd ? rd_mux : 16'h0000;
            o_synth_en <= !synth_off;
            o_vco_pulldown <= synth_off;
            o_up_req_n <= (pfd_nxt != PFD_UP);
            o_down_req_n <= (pfd_nxt != PFD_DOWN);
            o_err_out <= (pfd_nxt == PFD_DOWN);
            o_err_oe_n <= (pfd_nxt == PFD_IDLE);
        end
    end

    assign o_ref_tick = ref_tick_r;
    assign o_div_tick = div_tick_r;
    assign o_lock_loss_flag = flag_r;

    // ==================================================
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    status_ro_a: assert property (
        (i_reg.wr && i_reg.addr == `ADDR_LL_STATUS && !ll_clear && !flag_set && !dly_off)
        |=> (flag_r == $past(flag_r))) else $error("status changed by a write");
    read_clear_a: assert property (
        (ll_clear && !flag_set && !dly_off) |=> !flag_r) else $error("read did not clear flag");
    set_on_tick_a: assert property (
        (!flag_r && !flag_set && !dly_off) |=> !flag_r) else $error("flag set off tick");
    delay_filter_a: assert property (
        $rose(pend_r) |-> ($past(req_cnt_r) + 7'h01 >= $past(dly_thresh))) else $error("short request latched");
    short_req_a: assert property (
        (!req_on ##1 req_on [*2] ##1 !req_on) |-> !$past(long_req) || (dly_thresh <= 7'h02))
        else $error("two-cycle request passed filter");
    filter_off_a: assert property (
        dly_off |=> flag_r [*2]) else $error("flag dropped while filtering off");
    tune_off_a: assert property (
        !i_tune_en |=> (o_vco_pulldown && o_err_oe_n && !o_synth_en && o_up_req_n))
        else $error("not off with tune enable low");
    code_off_a: assert property (
        (ref_sel_r == `REF_CODE_OFF) |=> (o_vco_pulldown && o_err_oe_n && !div_tick_r && !ref_tick_r))
        else $error("not off with off code");
    sel_hold_a: assert property (
        (!i_tune_en && !wr_ref) |=> $stable(ref_sel_r)) else $error("select lost in tune reset");
    ref_period_a: assert property (
        ref_tick_r |-> (($past(ref_sel_r) == `REF_CODE_6K25 && $past(ref_cnt_r) == 12'(`REF_CYC_6K25 - 1)) ||
            ($past(ref_sel_r) == `REF_CODE_12K5 && $past(ref_cnt_r) == 12'(`REF_CYC_12K5 - 1)) ||
            ($past(ref_sel_r) == `REF_CODE_25K && $past(ref_cnt_r) == 12'(`REF_CYC_25K - 1))))
        else $error("reference period wrong");
    up_request_a: assert property (
        (pfd_r == PFD_IDLE && ref_tick_r && !div_tick_r && !synth_off) |=> (!o_up_req_n && !o_err_oe_n && !o_err_out))
        else $error("up request missing");
    div_tick_a: assert property (
        div_tick_r |-> $past(vco_rise && div_last)) else $error("divider tick without count");

    lock_lost_c: cover property (flag_set && !flag_r);
    read_clear_c: cover property (ll_clear && flag_r ##1 !flag_r);
    down_req_c: cover property (pfd_r == PFD_DOWN ##1 pfd_r == PFD_IDLE);
    tune_drop_c: cover property (!i_tune_en ##1 i_tune_en);
endmodule

// >>> synth_cfg.svh
`ifndef SYNTH_CFG_SVH
`define SYNTH_CFG_SVH
// ==================================================
// clock
`define MCLK_HZ 20000000
`define MCLK_NS (1000000000 / `MCLK_HZ)
// ==================================================
// register addresses
`define ADDR_REF_SEL 8'h13
`define ADDR_LL_STATUS 8'h22
`define ADDR_DLY_SEL 8'h32
`define ADDR_DIV_VAL 8'h41
// ==================================================
// field positions and reset values
`define LL_FLAG_BIT 0
`define DLY_CODE_W 2
`define REF_SEL_RST 4'hF
`define DLY_SEL_RST 2'h0
`define DIV_VAL_RST 16'h0000
// ==================================================
// reference step codes and rates
`define REF_CODE_6K25 4'h2
`define REF_CODE_12K5 4'h3
`define REF_CODE_25K 4'h6
`define REF_CODE_OFF 4'hF
`define REF_HZ_6K25 6250
`define REF_HZ_12K5 12500
`define REF_HZ_25K 25000
`define REF_CYC_6K25 (`MCLK_HZ / `REF_HZ_6K25)
`define REF_CYC_12K5 (`MCLK_HZ / `REF_HZ_12K5)
`define REF_CYC_25K (`MCLK_HZ / `REF_HZ_25K)
// ==================================================
// lock-loss delay codes, least times in ns, rounded up
`define DLY_CODE_MID 2'h0
`define DLY_CODE_LONG 2'h1
`define DLY_CODE_SHORT 2'h2
`define DLY_CODE_OFF 2'h3
`define DLY_MID_NS 1250
`define DLY_LONG_NS 3500
`define DLY_SHORT_NS 250
`define DLY_MID_CYC ((`DLY_MID_NS + `MCLK_NS - 1) / `MCLK_NS)
`define DLY_LONG_CYC ((`DLY_LONG_NS + `MCLK_NS - 1) / `MCLK_NS)
`define DLY_SHORT_CYC ((`DLY_SHORT_NS + `MCLK_NS - 1) / `MCLK_NS)
`endif

// >>> synth_pkg.sv
package synth_pkg;
    // ==================================================
    // register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    typedef enum logic [1:0] {
        PFD_IDLE,
        PFD_UP,
        PFD_DOWN
    } pfd_e;
endpackage

// >>> vco_model.sv
`timescale 1ns/1ps
// ==================================================
// prescaler and vco stand-in: square wave while released, held low when pulled down
module vco_model #(
    parameter int HALF = 5
) (
    input wire logic i_mclk,
    input wire logic i_pulldown,
    output logic o_vco_pre
);
    int cnt = 0;
    initial o_vco_pre = 1'b0;
    // a pulled-down vco input shows 0, never the last level
    always @(posedge i_mclk) begin
        if (i_pulldown) begin
            cnt <= 0;
            o_vco_pre <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            o_vco_pre <= ~o_vco_pre;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "synth_cfg.svh"
module tb_top;
    import synth_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_tune_en = 1'b1;
    logic vco_pre;
    reg_req_s req = '0;
    logic [15:0] rdata;
    logic en, pd, rtick, dtick, up_n, dn_n, eo, eo_oe_n, flag;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0, t1;
    logic [15:0] v;
    // ==================================================
    // clock, partner, design
    always #(`MCLK_NS / 2) i_mclk = ~i_mclk;
    vco_model #(.HALF(5)) partner (.i_mclk(i_mclk), .i_pulldown(pd), .o_vco_pre(vco_pre));
    synth_lock_loss_and_disable dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_tune_en(i_tune_en), .i_vco_pre(vco_pre), .i_reg(req),
        .o_reg_rdata(rdata), .o_synth_en(en), .o_vco_pulldown(pd), .o_ref_tick(rtick),
        .o_div_tick(dtick), .o_up_req_n(up_n), .o_down_req_n(dn_n), .o_err_out(eo),
        .o_err_oe_n(eo_oe_n), .o_lock_loss_flag(flag)
    );
    // ==================================================
    // tasks
    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_mclk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk) req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // waits for a ref (0) or div (1) tick, bounded; returns the cycle seen
    task automatic tick(input bit which, output int t);
        bit seen_tick;
        seen_tick = 1'b0;
        for (int i = 0; i < 20000 && !seen_tick; i++) begin
            @(posedge i_mclk);
            #1;
            seen_tick = ((which ? dtick : rtick) === 1'b1);
        end
        // a missing tick is a mismatch in itself
        if (!seen_tick) begin
            err_count++;
        end
        t = cyc;
    endtask
    // ==================================================
    // hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            give_verdict();
        end
    end
    // ==================================================
    // sequence
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(`ADDR_REF_SEL, v);
        chk(v, 16'h000F);
        chk({en, pd, eo_oe_n}, 3'h3);
        wr(`ADDR_DLY_SEL, 16'hFFFF);
        rd(`ADDR_DLY_SEL, v);
        chk(v, 16'h0003);
        rd(`ADDR_LL_STATUS, v);
        chk(v, 16'h0001);
        rd(`ADDR_LL_STATUS, v);
        chk(v, 16'h0001);
        wr(`ADDR_DLY_SEL, 16'h0000);
        wr(`ADDR_LL_STATUS, 16'h0000);
        rd(`ADDR_LL_STATUS, v);
        chk(v, 16'h0001);
        rd(`ADDR_LL_STATUS, v);
        chk(v, 16'h0000);
        chk(flag, 1'b0);
        // enable pin low, then high again: select value survives
        wr(`ADDR_REF_SEL, 16'h0002);
        @(posedge i_mclk) i_tune_en <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1 chk({en, pd, eo_oe_n}, 3'h3);
        rd(`ADDR_REF_SEL, v);
        chk(v, 16'h0002);
        wr(`ADDR_DIV_VAL, 16'h03E8);
        @(posedge i_mclk) i_tune_en <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1 chk({en, pd}, 2'h2);
        // divided rate (N=1000 of a 10-cycle vco) is below the reference: up requests
        tick(1'b0, t0);
        tick(1'b0, t1);
        chk(t1 - t0, `REF_CYC_6K25);
        @(posedge i_mclk);
        #1 chk({up_n, dn_n, eo, eo_oe_n}, 4'h4);
        tick(1'b0, t0);
        rd(`ADDR_LL_STATUS, v);
        chk(v, 16'h0001);
        tick(1'b1, t0);
        tick(1'b1, t1);
        chk(t1 - t0, 32'd10000);
        // divided rate (N=1) above the reference: down requests
        wr(`ADDR_DIV_VAL, 16'h0001);
        tick(1'b0, t0);
        tick(1'b0, t0);
        tick(1'b1, t1);
        @(posedge i_mclk);
        #1 chk({up_n, dn_n, eo, eo_oe_n}, 4'hA);
        // off code written during a tune-enable reset stays in force
        @(posedge i_mclk) i_tune_en <= 1'b0;
        wr(`ADDR_REF_SEL, 16'h000F);
        @(posedge i_mclk) i_tune_en <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1 chk({en, pd, up_n, dn_n, eo_oe_n}, 5'h0F);
        repeat (200) @(posedge i_mclk);
        #1 chk({rtick, dtick}, 2'h0);
        give_verdict();
    end
endmodule
